// >>> mspi_master.sv
// Master-only serial peripheral port with APB register access.
// Assumes sys_clk at 250 MHz, a synchronous active-low reset and an
// asynchronous serial input that is synchronised here.
//
// Overview of operation
// - Error flags unused, always read zero
// - Receive flag high while buffer holds data
// - Receiver disable flushes receive buffer
// - Transmit flag sets when shifter and buffer empty
// - Transmit flag cleared by service or one
// - Empty flag high when buffer free, after reset
// - Receive request needs enable, global, flag
// - Transmit request needs enable, global, flag
// - Empty request needs enable, global, flag
// - Receiver enable selects serial input pin
// - Receiver alone never starts a transfer
// - Transmitter disable waits until fully drained
// - Mode bits pick async, sync or master; only master transfers, async and sync codes leave the port idle
// - Format bits accepted with mode write
// - Bit order: one sends lsb first
// - Phase picks leading or trailing sample edge
// - Polarity sets idle level of clock
// - Double transmit buffer, extra receive level
// - No collision flag, no double-speed bit
// - Shift out and latch on opposite edges
// - Frames are exactly eight data bits
// - Data write starts a full-duplex transfer
// - Overflow drops newest character, keeps older
`timescale 1ns/1ps
`default_nettype none

module mspi_master (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial pins
    output mspi_pkg::pins_t pins,
    input wire logic serial_in_pin,
    // Interrupt requests and service acknowledge
    output logic irq_rx_done,
    output logic irq_tx_done,
    output logic irq_tx_empty,
    input wire logic tx_done_irq_ack
);

    // Whole module state
    typedef struct packed {
        mspi_pkg::ctrl_b_t cb;
        mspi_pkg::ctrl_c_t cc;
        logic [11:0] baud;
        logic gie;
        logic txc;
        logic [7:0] txbuf;
        logic txfull;
        logic txen_eff;
        logic [7:0] rxb0;
        logic [7:0] rxb1;
        logic [1:0] rxcnt;
        mspi_pkg::eng_t eng;
        logic [7:0] sh;
        logic [3:0] half;
        logic [11:0] cnt;
        logic rx_s1;
        logic rx_s2;
        logic [31:0] rdata;
        logic rdy;
        logic err;
        mspi_pkg::pins_t pins;
        logic irq_rx;
        logic irq_tx;
        logic irq_ue;
    } st_t;

    st_t s_r;
    st_t s_nxt;

    logic commit;
    logic mapped;
    logic master_serial_peripheral_mode;
    logic sample;
    logic [7:0] shin;
    logic out_bit;
    logic [1:0] cnt_pop;

    // Bus commit happens only at the edge where pready is seen high
    assign commit = psel && penable && s_r.rdy;
    assign mapped = (paddr == mspi_pkg::STATUS_OFS) ||
                    (paddr == mspi_pkg::CTRL_B_OFS) ||
                    (paddr == mspi_pkg::CTRL_C_OFS) ||
                    (paddr == mspi_pkg::DATA_OFS) ||
                    (paddr == mspi_pkg::BAUD_OFS) ||
                    (paddr == mspi_pkg::GLOBAL_OFS);
    assign master_serial_peripheral_mode = s_r.cc.mode == mspi_pkg::MODE_MASTER_SERIAL_PERIPHERAL_MODE;
    // Sample edge is leading when phase is zero, else trailing
    assign sample = s_r.half[0] == s_r.cc.cpha;
    assign out_bit = s_r.cc.lsb_first ? s_r.sh[0] : s_r.sh[7];
    // Input lags two cycles in its synchroniser: receive needs a divisor
    // of two or more, or the sample edge still sees the previous bit
    assign shin = s_r.cc.lsb_first ? {s_r.rx_s2, s_r.sh[7:1]}
                                   : {s_r.sh[6:0], s_r.rx_s2};

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        cnt_pop = s_r.rxcnt;
        // Two-flop input synchroniser
        s_nxt.rx_s1 = serial_in_pin;
        s_nxt.rx_s2 = s_r.rx_s1;

        // One wait state: answer registered, then committed
        if (psel && penable && !s_r.rdy) begin
            s_nxt.rdy = 1'b1;
            s_nxt.err = !mapped;
            s_nxt.rdata = 32'h0000_0000;
            unique case (paddr)
                mspi_pkg::STATUS_OFS: begin
                    // Error bits and reserved bits read zero
                    s_nxt.rdata[mspi_pkg::RXC_BIT] =
                        s_r.rxcnt != 2'h0;
                    s_nxt.rdata[mspi_pkg::TXC_BIT] = s_r.txc;
                    s_nxt.rdata[mspi_pkg::UDRE_BIT] =
                        !s_r.txfull;
                end
                mspi_pkg::CTRL_B_OFS: s_nxt.rdata[7:0] = s_r.cb;
                mspi_pkg::CTRL_C_OFS: s_nxt.rdata[7:0] = s_r.cc;
                mspi_pkg::DATA_OFS: s_nxt.rdata[7:0] = s_r.rxb0;
                mspi_pkg::BAUD_OFS: s_nxt.rdata[11:0] = s_r.baud;
                mspi_pkg::GLOBAL_OFS:
                    s_nxt.rdata[mspi_pkg::GIE_BIT] = s_r.gie;
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
        end else begin
            s_nxt.rdy = 1'b0;
            s_nxt.err = 1'b0;
        end

        // Register writes; no collision flag, no double speed bit
        if (commit && pwrite) begin
            unique case (paddr)
                mspi_pkg::STATUS_OFS:
                    if (pwdata[mspi_pkg::TXC_BIT])
                        s_nxt.txc = 1'b0;
                mspi_pkg::CTRL_B_OFS: begin
                    s_nxt.cb = pwdata[7:0];
                    if (pwdata[3])
                        s_nxt.txen_eff = 1'b1;
                end
                // Mode and format land in one write
                mspi_pkg::CTRL_C_OFS: s_nxt.cc = pwdata[7:0];
                mspi_pkg::DATA_OFS:
                    // Write to a full buffer is dropped
                    if (!s_r.txfull) begin
                        s_nxt.txbuf = pwdata[7:0];
                        s_nxt.txfull = 1'b1;
                    end
                mspi_pkg::BAUD_OFS: s_nxt.baud = pwdata[11:0];
                mspi_pkg::GLOBAL_OFS:
                    s_nxt.gie = pwdata[mspi_pkg::GIE_BIT];
                default: s_nxt.gie = s_r.gie;
            endcase
        end

        // Serviced interrupt clears the transmit flag
        if (tx_done_irq_ack)
            s_nxt.txc = 1'b0;

        // Reading data pops the receive queue head
        if (commit && !pwrite && paddr == mspi_pkg::DATA_OFS &&
            s_r.rxcnt != 2'h0) begin
            s_nxt.rxb0 = s_r.rxb1;
            cnt_pop = s_r.rxcnt - 2'h1;
        end
        s_nxt.rxcnt = cnt_pop;

        // Shift engine
        unique case (s_r.eng)
            mspi_pkg::ST_IDLE: begin
                s_nxt.pins.xck = s_r.cc.cpol;
                // Line rests high between frames
                s_nxt.pins.txd = mspi_pkg::TXD_IDLE_BYTE[0];
                // Only the transmitter makes the clock
                if (s_r.txfull && s_r.txen_eff && master_serial_peripheral_mode) begin
                    s_nxt.sh = s_r.txbuf;
                    s_nxt.txfull = 1'b0;
                    s_nxt.eng = mspi_pkg::ST_SHIFT;
                    s_nxt.half = 4'h0;
                    s_nxt.cnt = s_r.baud;
                    // Phase zero: first bit ready before first edge
                    if (!s_r.cc.cpha)
                        s_nxt.pins.txd = s_r.cc.lsb_first ?
                            s_r.txbuf[0] : s_r.txbuf[7];
                end
            end
            mspi_pkg::ST_SHIFT: begin
                if (s_r.cnt == 12'h000) begin
                    // Half period is baud+1 system clocks
                    s_nxt.cnt = s_r.baud;
                    s_nxt.pins.xck = !s_r.pins.xck;
                    if (sample)
                        s_nxt.sh = shin;
                    else
                        s_nxt.pins.txd = out_bit;
                    s_nxt.half = s_r.half + 4'h1;
                    if (s_r.half == mspi_pkg::LAST_HALF) begin
                        s_nxt.eng = mspi_pkg::ST_IDLE;
                        // Last bit stays put through its own sample edge
                        if (!sample)
                            s_nxt.pins.txd = mspi_pkg::TXD_IDLE_BYTE[0];
                        // Full queue drops the new byte
                        if (s_r.cb.rxen &&
                            cnt_pop != 2'(mspi_pkg::RX_DEPTH)) begin
                            if (cnt_pop == 2'h0)
                                s_nxt.rxb0 = sample ? shin : s_r.sh;
                            else
                                s_nxt.rxb1 = sample ? shin : s_r.sh;
                            s_nxt.rxcnt = cnt_pop + 2'h1;
                        end
                        // Set wins over a clear in the same cycle
                        if (!s_r.txfull)
                            s_nxt.txc = 1'b1;
                    end
                end else begin
                    s_nxt.cnt = s_r.cnt - 12'h001;
                end
            end
            default: s_nxt.eng = mspi_pkg::ST_IDLE;
        endcase

        // Disabled transmitter lets go once fully drained; the new enable
        // is used so that a re-enable on an idle port is not undone
        if (!s_nxt.cb.txen && s_r.eng == mspi_pkg::ST_IDLE &&
            !s_r.txfull)
            s_nxt.txen_eff = 1'b0;

        // Receiver off flushes the queue
        if (!s_r.cb.rxen)
            s_nxt.rxcnt = 2'h0;

        // Pin ownership
        s_nxt.pins.txd_oe = s_nxt.txen_eff;
        s_nxt.pins.rxd_sel = s_nxt.cb.rxen;

        // Interrupt requests gated by enable and global flag
        s_nxt.irq_rx = s_r.cb.rxie && s_r.gie &&
                       s_r.rxcnt != 2'h0;
        s_nxt.irq_tx = s_r.cb.txie && s_r.gie && s_r.txc;
        s_nxt.irq_ue = s_r.cb.tx_empty_irq_enable && s_r.gie && !s_r.txfull;
    end

    // State register
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            s_r <= '0;
            s_r.cb <= mspi_pkg::CTRL_B_RST;
            s_r.cc <= mspi_pkg::CTRL_C_RST;
            s_r.baud <= mspi_pkg::BAUD_RST;
            s_r.eng <= mspi_pkg::ST_IDLE;
            s_r.pins.txd <= mspi_pkg::TXD_IDLE_BYTE[0];
            s_r.rx_s1 <= 1'b1;
            s_r.rx_s2 <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from the state register
    assign prdata = s_r.rdata;
    assign pready = s_r.rdy;
    assign pslverr = s_r.err;
    assign pins = s_r.pins;
    assign irq_rx_done = s_r.irq_rx;
    assign irq_tx_done = s_r.irq_tx;
    assign irq_tx_empty = s_r.irq_ue;

    // Checks
    default clocking cb_chk @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    logic rd_status;
    assign rd_status = psel && penable && !s_r.rdy && !pwrite &&
                       paddr == mspi_pkg::STATUS_OFS;

    sequence s_last_edge;
        s_r.eng == mspi_pkg::ST_SHIFT && s_r.cnt == 12'h000 &&
        s_r.half == mspi_pkg::LAST_HALF;
    endsequence

    sequence s_start;
        s_r.eng == mspi_pkg::ST_IDLE && s_r.txfull &&
        s_r.txen_eff && master_serial_peripheral_mode;
    endsequence

    a_err_bits_zero: assert property (
        rd_status |=> pready && prdata[4:0] == 5'h00)
        else $error("error bits not zero");
    a_rxc_reads: assert property (
        rd_status |=> prdata[mspi_pkg::RXC_BIT] ==
                      ($past(s_r.rxcnt) != 2'h0))
        else $error("receive flag wrong");
    a_rx_flush: assert property (
        !s_r.cb.rxen |=> s_r.rxcnt == 2'h0)
        else $error("receive queue not flushed");
    a_txc_set: assert property (
        s_last_edge ##0 !s_r.txfull |=> s_r.txc)
        else $error("transmit flag not set");
    a_txc_ack: assert property (
        tx_done_irq_ack && !s_last_edge |=> !s_r.txc)
        else $error("transmit flag not cleared");
    a_udre_reset: assert property (
        $rose(rst_b) |-> !s_r.txfull ##1 irq_tx_empty == 1'b0)
        else $error("empty flag not set after reset");
    a_rx_irq: assert property (
        irq_rx_done |-> $past(s_r.cb.rxie && s_r.gie))
        else $error("receive request without enable");
    a_tx_irq: assert property (
        irq_tx_done |-> $past(s_r.txc && s_r.gie))
        else $error("transmit request without flag");
    a_no_rx_only: assert property (
        s_r.eng == mspi_pkg::ST_IDLE && !s_r.txen_eff
        |=> s_r.eng == mspi_pkg::ST_IDLE)
        else $error("transfer without transmitter");
    a_tx_hold: assert property (
        s_r.txen_eff && s_r.eng == mspi_pkg::ST_SHIFT
        |=> pins.txd_oe && s_r.txen_eff)
        else $error("transmit pin released early");
    a_frame_start: assert property (
        s_start |=> s_r.eng == mspi_pkg::ST_SHIFT && s_r.half == 4'h0)
        else $error("frame did not start");
    a_rx_overflow: assert property (
        s_last_edge ##0 s_r.rxcnt == 2'h2 && !commit
        |=> $stable(s_r.rxb0) && $stable(s_r.rxb1))
        else $error("buffered data overwritten");
    a_empty_irq: assert property (
        irq_tx_empty == $past(s_r.cb.tx_empty_irq_enable && s_r.gie && !s_r.txfull))
        else $error("empty request mismatch");
    a_mode_gate: assert property (
        s_r.eng == mspi_pkg::ST_IDLE && !master_serial_peripheral_mode
        |=> s_r.eng == mspi_pkg::ST_IDLE)
        else $error("transfer outside master mode");
    a_xck_idle: assert property (
        s_r.eng == mspi_pkg::ST_IDLE |=> pins.xck == $past(s_r.cc.cpol))
        else $error("clock not at idle level");
    a_frame_end: assert property (
        s_last_edge |=> s_r.eng == mspi_pkg::ST_IDLE && s_r.half == 4'h0)
        else $error("frame length wrong");
    a_rx_pop: assert property (
        commit && !pwrite && paddr == mspi_pkg::DATA_OFS &&
        s_r.rxcnt == 2'h2 && s_r.cb.rxen
        |=> s_r.rxb0 == $past(s_r.rxb1))
        else $error("receive queue order wrong");
    a_rx_pin: assert property (
        pins.rxd_sel == s_r.cb.rxen)
        else $error("receive pin ownership wrong");
    a_txc_w1c: assert property (
        commit && pwrite && paddr == mspi_pkg::STATUS_OFS &&
        pwdata[mspi_pkg::TXC_BIT] && !s_last_edge |=> !s_r.txc)
        else $error("transmit flag write clear failed");

endmodule : mspi_master

`default_nettype wire

// >>> mspi_pkg.sv
// Package for the master-only serial peripheral port: register map,
// field layouts, reset values, state codes and carrier structs.
// Assumes a 32-bit APB slave with one aligned word per register.
package mspi_pkg;
    // Register byte offsets
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] CTRL_B_OFS = 8'h04;
    localparam logic [7:0] CTRL_C_OFS = 8'h08;
    localparam logic [7:0] DATA_OFS = 8'h0C;
    localparam logic [7:0] BAUD_OFS = 8'h10;
    localparam logic [7:0] GLOBAL_OFS = 8'h14;
    // Status bit positions
    localparam int RXC_BIT = 7;
    localparam int TXC_BIT = 6;
    localparam int UDRE_BIT = 5;
    // Global interrupt enable position in the global register
    localparam int GIE_BIT = 0;
    // Mode select encoding
    localparam logic [1:0] MODE_ASYNC = 2'h0;
    localparam logic [1:0] MODE_SYNC = 2'h1;
    localparam logic [1:0] MODE_MASTER_SERIAL_PERIPHERAL_MODE = 2'h3;
    // Reset values
    localparam logic [7:0] CTRL_B_RST = 8'h00;
    localparam logic [7:0] CTRL_C_RST = 8'h00;
    localparam logic [11:0] BAUD_RST = 12'h000;
    localparam logic [7:0] TXD_IDLE_BYTE = 8'hFF;
    // Frame of 8 bits is 16 clock half-periods
    localparam logic [3:0] LAST_HALF = 4'hF;
    localparam int RX_DEPTH = 2;

    // Interrupt and enable control register layout
    typedef struct packed {
        logic rxie;
        logic txie;
        logic tx_empty_irq_enable;
        logic rxen;
        logic txen;
        logic [2:0] rsvd;
    } ctrl_b_t;

    // Mode and format control register layout
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] rsvd;
        logic lsb_first;
        logic cpha;
        logic cpol;
    } ctrl_c_t;

    // Serial pin group
    typedef struct packed {
        logic xck;
        logic txd;
        logic txd_oe;
        logic rxd_sel;
    } pins_t;

    // Shift engine states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SHIFT = 2'b10
    } eng_t;
endpackage : mspi_pkg

// >>> spi_slave_model.sv
// Behavioural slave on the serial link: shifts a reply out and captures
// what the master sends. Its select is tied on by board logic, so it
// drives its output between frames as well.
`timescale 1ns/1ps
`default_nettype none

module spi_slave_model (
    // Link
    input wire logic xck,
    input wire logic mosi,
    output logic miso,
    // Setup: clear, mode {lsb first, phase, polarity}, reply base
    input wire logic clr,
    input wire logic [2:0] cfg,
    input wire logic [7:0] reply,
    // Observed
    output logic [7:0] got,
    output int n_frames
);
    logic [7:0] sh;
    int ns;

    // Reply bit i of this frame; reply value steps once per frame
    function automatic logic pick(input int i);
        logic [7:0] b;
        b = reply + 8'(n_frames);
        return cfg[2] ? b[i] : b[7 - i];
    endfunction : pick

    // Sample and setup on opposite edges; a mode change needs clr,
    // since the idle level moving looks like an edge
    always @(xck or posedge clr) begin
        if (clr) begin
            ns = 0;
            n_frames = 0;
            miso = pick(0);
        end else if ((xck != cfg[0]) != cfg[1]) begin
            sh = cfg[2] ? {mosi, sh[7:1]} : {sh[6:0], mosi};
            ns++;
            if (ns == 8) begin
                ns = 0;
                got = sh;
                n_frames++;
            end
        end else begin
            miso = pick(ns);
        end
    end
endmodule : spi_slave_model
`default_nettype wire

// >>> tb_usart_master_spi_mode.sv
// Testbench for the master serial port: APB register access, transfers
// in all clock modes, buffering, interrupt requests and the divisor.
// Assumes mspi_pkg, mspi_master and spi_slave_model compile before it.
`timescale 1ns/1ps
`default_nettype none

module tb_usart_master_spi_mode;
    // Bench signals
    logic sys_clk, rst_b, psel, penable, pwrite, tx_done_irq_ack, clr, e;
    logic [7:0] paddr, reply, got;
    logic [31:0] pwdata, prdata, q;
    logic pready, pslverr, miso, irq_rx_done, irq_tx_done, irq_tx_empty;
    logic [2:0] cfg;
    mspi_pkg::pins_t pins;
    int n_mismatch, n_tests, cyc, nf, f, n;

    mspi_master i_mspi_master (.sys_clk(sys_clk), .rst_b(rst_b),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .serial_in_pin(miso),
        .irq_rx_done(irq_rx_done), .irq_tx_done(irq_tx_done),
        .irq_tx_empty(irq_tx_empty), .tx_done_irq_ack(tx_done_irq_ack));

    // Slave select handled by board logic: model always selected
    spi_slave_model i_spi_slave_model (.xck(pins.xck), .mosi(pins.txd),
        .miso(miso), .clr(clr), .cfg(cfg), .reply(reply), .got(got),
        .n_frames(nf));

    // Clock, 4 ns period
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Hang guard; tests need well under this many cycles
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask : chk

    // APB transfer; holds the request until pready, no assumed latency
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // One idle edge, so no signal is driven twice in one step
        @(posedge sys_clk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, x);
    endtask : rd

    task automatic wt(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h00_0000, d});
    endtask : wt

    // Poll a status bit until set; hang guard bounds it
    task automatic wait_st(input int b);
        do apb(1'b0, mspi_pkg::STATUS_OFS, 32'h0000_0000);
        while (q[b] !== 1'b1);
    endtask : wait_st

    task automatic irqs(input logic [2:0] x);
        repeat (2) @(posedge sys_clk);
        chk({irq_rx_done, irq_tx_done, irq_tx_empty}, x);
    endtask : irqs

    // One full-duplex byte, both directions compared
    task automatic xfer(input logic [7:0] d);
        f = nf;
        wt(mspi_pkg::DATA_OFS, d);
        wait_st(mspi_pkg::RXC_BIT);
        chk(got, d);
        rd(mspi_pkg::DATA_OFS, reply + 8'(f));
    endtask : xfer

    initial begin
        rst_b = 1'b0;
        {psel, penable, pwrite, tx_done_irq_ack} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        {clr, cfg, reply} = {1'b1, 3'h0, 8'h3C};
        {cyc, n_mismatch, n_tests} = 0;
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        clr <= 1'b0;
        @(posedge sys_clk);
        rd(mspi_pkg::STATUS_OFS, 32'h0000_0020);
        rd(mspi_pkg::CTRL_C_OFS, 32'h0000_0000);
        rd(8'h1C, 32'h0000_0000);
        chk(e, 1'b1);
        $display("test reset_and_map done");
        // Receiver alone: pin taken over, yet no clock
        wt(mspi_pkg::GLOBAL_OFS, 8'h01);
        wt(mspi_pkg::BAUD_OFS, 8'h02);
        wt(mspi_pkg::CTRL_C_OFS, 8'hC0);
        wt(mspi_pkg::CTRL_B_OFS, 8'h10);
        wt(mspi_pkg::DATA_OFS, 8'h81);
        repeat (60) @(posedge sys_clk);
        chk({pins.rxd_sel, pins.txd_oe}, 2'b10);
        chk(nf, 0);
        wt(mspi_pkg::CTRL_B_OFS, 8'h18);
        wait_st(mspi_pkg::RXC_BIT);
        chk(pins.txd_oe, 1'b1);
        chk(got, 8'h81);
        rd(mspi_pkg::DATA_OFS, {24'h00_0000, reply});
        rd(mspi_pkg::STATUS_OFS, 32'h0000_0060);
        wt(mspi_pkg::STATUS_OFS, 8'h40);
        rd(mspi_pkg::STATUS_OFS, 32'h0000_0020);
        $display("test enables done");
        // Every mode and bit order, format set with the mode write
        for (int m = 0; m < 8; m++) begin
            cfg <= m[2:0];
            clr <= 1'b1;
            wt(mspi_pkg::CTRL_C_OFS, 8'hC0 | 8'(m));
            repeat (3) @(posedge sys_clk);
            clr <= 1'b0;
            xfer(8'h96 + 8'(m));
            chk(pins.xck, m[0]);
            chk(pins.txd, 1'b1);
        end
        $display("test modes done");
        // Double buffer, then overflow drops the newest byte
        wt(mspi_pkg::STATUS_OFS, 8'h40);
        f = nf;
        wt(mspi_pkg::DATA_OFS, 8'h11);
        wt(mspi_pkg::DATA_OFS, 8'h22);
        rd(mspi_pkg::STATUS_OFS, 32'h0000_0000);
        wait_st(mspi_pkg::UDRE_BIT);
        wt(mspi_pkg::DATA_OFS, 8'h33);
        wait_st(mspi_pkg::TXC_BIT);
        rd(mspi_pkg::DATA_OFS, reply + 8'(f));
        rd(mspi_pkg::DATA_OFS, reply + 8'(f + 1));
        rd(mspi_pkg::STATUS_OFS, 32'h0000_0060);
        $display("test buffering done");
        // Interrupt requests, service acknowledge, global enable
        wt(mspi_pkg::CTRL_B_OFS, 8'hF8);
        irqs(3'b011);
        tx_done_irq_ack <= 1'b1;
        @(posedge sys_clk);
        tx_done_irq_ack <= 1'b0;
        irqs(3'b001);
        wt(mspi_pkg::GLOBAL_OFS, 8'h00);
        irqs(3'b000);
        wt(mspi_pkg::GLOBAL_OFS, 8'h01);
        wt(mspi_pkg::DATA_OFS, 8'h5A);
        wait_st(mspi_pkg::RXC_BIT);
        irqs(3'b111);
        wt(mspi_pkg::CTRL_B_OFS, 8'h08);
        rd(mspi_pkg::STATUS_OFS, 32'h0000_0060);
        $display("test interrupts done");
        // Transmitter off mid-frame waits for both stages to drain
        wt(mspi_pkg::CTRL_B_OFS, 8'h18);
        wt(mspi_pkg::STATUS_OFS, 8'h40);
        wt(mspi_pkg::DATA_OFS, 8'hC3);
        wt(mspi_pkg::DATA_OFS, 8'h3C);
        wt(mspi_pkg::CTRL_B_OFS, 8'h10);
        chk(pins.txd_oe, 1'b1);
        wait_st(mspi_pkg::TXC_BIT);
        repeat (2) @(posedge sys_clk);
        chk(pins.txd_oe, 1'b0);
        chk(got, 8'h3C);
        $display("test drain done");
        // Divisor 3: clock half period of 4 system cycles
        wt(mspi_pkg::CTRL_B_OFS, 8'h18);
        wt(mspi_pkg::BAUD_OFS, 8'h03);
        wt(mspi_pkg::DATA_OFS, 8'hAA);
        do @(posedge sys_clk); while (pins.xck === cfg[0]);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pins.xck !== cfg[0]);
        chk(n, 4);
        wait_st(mspi_pkg::RXC_BIT);
        $display("test divisor done");
        wrap_up();
    end
endmodule : tb_usart_master_spi_mode
`default_nettype wire
